// ### hw/cex_pkg.sv
package cex_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;

  // Opcodes of the supported slice; '?' marks register or pointer select bits.
  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [7:0] OP_CTAB_DP = 8'h93;
  localparam logic [7:0] OP_CTAB_PG = 8'h83;
  localparam logic [7:0] OP_XRD_DP  = 8'hE0;
  localparam logic [7:0] OP_XRD_RI  = 8'b1110_001?;
  localparam logic [7:0] OP_XWR_DP  = 8'hF0;
  localparam logic [7:0] OP_XWR_RI  = 8'b1111_001?;
  localparam logic [7:0] OP_UMUL    = 8'hA4;
  localparam logic [7:0] OP_OR_RN   = 8'b0100_1???;
  localparam logic [7:0] OP_OR_DIR  = 8'h45;
  localparam logic [7:0] OP_OR_RI   = 8'b0100_011?;
  localparam logic [7:0] OP_OR_IMM  = 8'h44;
  localparam logic [7:0] OP_OR_DA   = 8'h42;
  localparam logic [7:0] OP_OR_DI   = 8'h43;
  localparam logic [7:0] OP_COR_BIT = 8'h72;
  localparam logic [7:0] OP_COR_NOT = 8'hA0;
  localparam logic [7:0] OP_POP     = 8'hD0;
  localparam logic [7:0] OP_PUSH    = 8'hC0;

  // Special function register direct addresses.
  localparam logic [7:0] SFR_LOWPORT  = 8'h80;
  localparam logic [7:0] SFR_STACK    = 8'h81;
  localparam logic [7:0] SFR_PTR_LO   = 8'h82;
  localparam logic [7:0] SFR_PTR_HI   = 8'h83;
  localparam logic [7:0] SFR_GPPORT   = 8'h90;
  localparam logic [7:0] SFR_HIGHPORT = 8'hA0;
  localparam logic [7:0] SFR_STATUS   = 8'hD0;
  localparam logic [7:0] SFR_ACC      = 8'hE0;
  localparam logic [7:0] SFR_BREG     = 8'hF0;

  // Bit-addressable RAM starts here; bit addresses below 0x80 map into it.
  localparam logic [7:0] BITRAM_BASE = 8'h20;

  // Status word field positions.
  localparam int ST_CY  = 7;
  localparam int ST_RS1 = 4;
  localparam int ST_RS0 = 3;
  localparam int ST_OVF = 2;

  // Reset values.
  localparam logic [7:0]  STACK_RESET = 8'h07;
  localparam logic [7:0]  PORT_RESET  = 8'hFF;
  localparam logic [15:0] PROG_RESET  = 16'h0000;

  // Multiply takes decode, this many wait cycles, then the write-back cycle.
  localparam logic [1:0] MUL_WAIT = 2'h2;

  typedef enum logic [2:0] {S_FETCH, S_OPER, S_IMM, S_CODE, S_XFER, S_MUL} cex_state_t;

endpackage

// ### hw/cex_xbus_if.sv
`timescale 1ns/100ps
interface cex_xbus_if;
  logic        start;
  logic        write;
  logic        useDataPtr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  highPortLatch;
  logic [7:0]  rdata;

  modport core (output start, write, useDataPtr, addr, wdata, highPortLatch, input rdata);
  modport port (input start, write, useDataPtr, addr, wdata, highPortLatch, output rdata);
endinterface

// ### hw/cex_xdata_port.sv
`timescale 1ns/100ps
module cex_xdata_port
  import cex_pkg::*;
(
  input  logic                      core_clk,
  input  logic                      reset,
  cex_xbus_if.port                  bus,
  input  logic [cex_pkg::BYTE_W-1:0] lowPortIn,
  output logic [cex_pkg::BYTE_W-1:0] lowPortOut,
  output logic                      lowPortOe_n,
  output logic [cex_pkg::BYTE_W-1:0] highPortOut,
  output logic                      addrLatchEn,
  output logic                      readStrobe_n,
  output logic                      writeStrobe_n
);
  import cex_pkg::*;

  typedef struct packed {
    logic       inData;
    logic       write;
    logic       useDataPtr;
    logic [7:0] high;
    logic [7:0] wdata;
  } cex_xport_t;

  cex_xport_t s;
  cex_xport_t n;

  // Address phase is the decode cycle, data phase the cycle after it.
  always_comb
  begin
    n        = s;
    n.inData = 1'b0;
    if (bus.start)
    begin
      n.inData     = 1'b1;
      n.write      = bus.write;
      n.useDataPtr = bus.useDataPtr;
      n.high       = bus.addr[15:8];
      n.wdata      = bus.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      s <= '0;
    else
      s <= n;
  end

  // The low address is on the port with the latch enable before any data.
  assign addrLatchEn   = bus.start;
  assign lowPortOut    = bus.start ? bus.addr[7:0] : s.wdata;
  assign lowPortOe_n   = ~(bus.start | (s.inData & s.write));
  assign readStrobe_n  = ~(s.inData & ~s.write);
  assign writeStrobe_n = ~(s.inData & s.write);

  // Pointer high byte drives the pins only; the port latch is never written here.
  always_comb
  begin
    if (bus.start && bus.useDataPtr)
      highPortOut = bus.addr[15:8];
    else if (s.inData && s.useDataPtr)
      highPortOut = s.high;
    else
      highPortOut = bus.highPortLatch;
  end

  assign bus.rdata = lowPortIn;

endmodule // cex_xdata_port

// ### hw/cex_exec_top.sv
`timescale 1ns/100ps
module cex_exec_top
  import cex_pkg::*;
(
  input  logic                      core_clk,
  input  logic                      reset,
  output logic [cex_pkg::ADDR_W-1:0] codeAddr,
  input  logic [cex_pkg::BYTE_W-1:0] codeData,
  input  logic [cex_pkg::BYTE_W-1:0] lowPortIn,
  output logic [cex_pkg::BYTE_W-1:0] lowPortOut,
  output logic                      lowPortOe_n,
  output logic [cex_pkg::BYTE_W-1:0] highPortOut,
  output logic                      addrLatchEn,
  output logic                      readStrobe_n,
  output logic                      writeStrobe_n,
  input  logic [cex_pkg::BYTE_W-1:0] gpPortPins,
  output logic [cex_pkg::BYTE_W-1:0] gpPortOut,
  output logic [cex_pkg::BYTE_W-1:0] accOut,
  output logic [cex_pkg::BYTE_W-1:0] bRegOut,
  output logic [cex_pkg::BYTE_W-1:0] statusOut,
  output logic [cex_pkg::BYTE_W-1:0] stackOut,
  output logic [cex_pkg::ADDR_W-1:0] dataPtrOut,
  output logic                      instrBoundary,
  output logic                      unsupportedOp
);
  import cex_pkg::*;

  typedef struct packed {
    cex_state_t      st;
    logic [15:0]     progCnt;
    logic [15:0]     codeAddr;
    logic [7:0]      opcode;
    logic [7:0]      dirAddr;
    logic [1:0]      cnt;
    logic [7:0]      acc;
    logic [7:0]      bReg;
    logic [7:0]      status;
    logic [7:0]      stackPtr;
    logic [7:0]      ptrLo;
    logic [7:0]      ptrHi;
    logic [7:0]      lowLatch;
    logic [7:0]      gpLatch;
    logic [7:0]      highLatch;
    logic [255:0][7:0] iram;
  } cex_core_t;

  cex_core_t s;
  cex_core_t n;

  cex_xbus_if xbus ();

  // Reads a direct byte; port reads take the latch when the access writes it back.
  function automatic logic [7:0] rdDir(input cex_core_t c, input logic [7:0] a,
                                       input logic [7:0] pins, input logic useLatch);
    logic [7:0] v;
    v = 8'h00;
    if (!a[7])
      v = c.iram[a];
    else
    begin
      unique case (a)
        SFR_LOWPORT:  v = c.lowLatch;
        SFR_STACK:    v = c.stackPtr;
        SFR_PTR_LO:   v = c.ptrLo;
        SFR_PTR_HI:   v = c.ptrHi;
        SFR_GPPORT:   v = useLatch ? c.gpLatch : pins;
        SFR_HIGHPORT: v = c.highLatch;
        SFR_STATUS:   v = c.status;
        SFR_ACC:      v = c.acc;
        SFR_BREG:     v = c.bReg;
        default:      v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Writes a direct byte; unmapped special addresses are ignored.
  function automatic cex_core_t wrDir(input cex_core_t c, input logic [7:0] a,
                                      input logic [7:0] v);
    cex_core_t r;
    r = c;
    if (!a[7])
      r.iram[a] = v;
    else
    begin
      unique case (a)
        SFR_LOWPORT:  r.lowLatch = v;
        SFR_STACK:    r.stackPtr = v;
        SFR_PTR_LO:   r.ptrLo = v;
        SFR_PTR_HI:   r.ptrHi = v;
        SFR_GPPORT:   r.gpLatch = v;
        SFR_HIGHPORT: r.highLatch = v;
        SFR_STATUS:   r.status = v;
        SFR_ACC:      r.acc = v;
        SFR_BREG:     r.bReg = v;
        default:      r = c;
      endcase
    end
    return r;
  endfunction

  // Reads one addressable bit without changing it.
  function automatic logic rdBit(input cex_core_t c, input logic [7:0] ba,
                                 input logic [7:0] pins);
    logic [7:0] byteAddr;
    logic [7:0] v;
    byteAddr = ba[7] ? {ba[7:3], 3'b000} : BITRAM_BASE + {4'h0, ba[6:3]};
    v        = rdDir(c, byteAddr, pins, 1'b0);
    return v[ba[2:0]];
  endfunction

  logic [7:0]  op;
  logic [7:0]  bank;
  logic [7:0]  rnIdx;
  logic [7:0]  riIdx;
  logic [7:0]  riVal;
  logic [7:0]  srcVal;
  logic [15:0] product;
  logic        bitVal;

  always_comb
  begin
    n             = s;
    op            = codeData;
    bank          = {3'b000, s.status[ST_RS1], s.status[ST_RS0], 3'b000};
    rnIdx         = bank | {5'h00, codeData[2:0]};
    riIdx         = bank | {7'h00, codeData[0]};
    riVal         = s.iram[riIdx];
    srcVal        = 8'h00;
    product       = 16'h0000;
    bitVal        = 1'b0;
    instrBoundary = 1'b0;
    unsupportedOp = 1'b0;
    xbus.start        = 1'b0;
    xbus.write        = 1'b0;
    xbus.useDataPtr   = 1'b0;
    xbus.addr         = 16'h0000;
    xbus.wdata        = s.acc;
    xbus.highPortLatch = s.highLatch;

    unique case (s.st)
      S_FETCH:
      begin
        // Decode happens only here, so no instruction is ever split.
        instrBoundary = 1'b1;
        n.opcode      = op;
        n.progCnt     = s.progCnt + 16'h0001;
        n.codeAddr    = n.progCnt;
        casez (op)
          OP_IDLE:
          begin
            // One cycle; only the counter moves.
          end
          OP_OR_RN:
            n.acc = s.acc | s.iram[rnIdx];
          OP_OR_RI:
            n.acc = s.acc | s.iram[riVal];
          OP_CTAB_DP:
          begin
            n.codeAddr = {s.ptrHi, s.ptrLo} + {8'h00, s.acc};
            n.st       = S_CODE;
          end
          OP_CTAB_PG:
          begin
            n.codeAddr = n.progCnt + {8'h00, s.acc};
            n.st       = S_CODE;
          end
          OP_XRD_DP, OP_XWR_DP:
          begin
            xbus.start      = 1'b1;
            xbus.write      = op[4];
            xbus.useDataPtr = 1'b1;
            xbus.addr       = {s.ptrHi, s.ptrLo};
            n.st            = S_XFER;
          end
          OP_XRD_RI, OP_XWR_RI:
          begin
            xbus.start = 1'b1;
            xbus.write = op[4];
            xbus.addr  = {8'h00, riVal};
            n.st       = S_XFER;
          end
          OP_UMUL:
          begin
            n.cnt = MUL_WAIT;
            n.st  = S_MUL;
          end
          OP_OR_DIR, OP_OR_IMM, OP_OR_DA, OP_OR_DI, OP_COR_BIT, OP_COR_NOT,
          OP_POP, OP_PUSH:
            n.st = S_OPER;
          default:
            unsupportedOp = 1'b1;
        endcase
      end

      S_OPER:
      begin
        n.progCnt  = s.progCnt + 16'h0001;
        n.codeAddr = n.progCnt;
        n.st       = S_FETCH;
        unique case (s.opcode)
          OP_OR_DIR:
            n.acc = s.acc | rdDir(s, codeData, gpPortPins, 1'b0);
          OP_OR_IMM:
            n.acc = s.acc | codeData;
          OP_OR_DA:
            n = wrDir(n, codeData, rdDir(s, codeData, gpPortPins, 1'b1) | s.acc);
          OP_OR_DI:
          begin
            n.dirAddr = codeData;
            n.st      = S_IMM;
          end
          OP_COR_BIT:
          begin
            bitVal = rdBit(s, codeData, gpPortPins);
            if (bitVal)
              n.status[ST_CY] = 1'b1;
          end
          OP_COR_NOT:
          begin
            bitVal = ~rdBit(s, codeData, gpPortPins);
            if (bitVal)
              n.status[ST_CY] = 1'b1;
          end
          OP_POP:
          begin
            srcVal     = s.iram[s.stackPtr];
            n.stackPtr = s.stackPtr - 8'h01;
            n          = wrDir(n, codeData, srcVal);
          end
          OP_PUSH:
          begin
            srcVal             = rdDir(s, codeData, gpPortPins, 1'b0);
            n.stackPtr         = s.stackPtr + 8'h01;
            n.iram[n.stackPtr] = srcVal;
          end
          default:
            unsupportedOp = 1'b1;
        endcase
      end

      S_IMM:
      begin
        n.progCnt  = s.progCnt + 16'h0001;
        n.codeAddr = n.progCnt;
        n          = wrDir(n, s.dirAddr,
                           rdDir(s, s.dirAddr, gpPortPins, 1'b1) | codeData);
        n.st       = S_FETCH;
      end

      S_CODE:
      begin
        n.acc      = codeData;
        n.codeAddr = s.progCnt;
        n.st       = S_FETCH;
      end

      S_XFER:
      begin
        if (!s.opcode[4])
          n.acc = xbus.rdata;
        n.st = S_FETCH;
      end

      S_MUL:
      begin
        if (s.cnt != 2'h0)
          n.cnt = s.cnt - 2'h1;
        else
        begin
          product          = s.acc * s.bReg;
          n.acc            = product[7:0];
          n.bReg           = product[15:8];
          n.status[ST_OVF] = |product[15:8];
          n.status[ST_CY]  = 1'b0;
          n.st             = S_FETCH;
        end
      end

      default:
        n.st = S_FETCH;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s           <= '0;
      s.st        <= S_FETCH;
      s.progCnt   <= PROG_RESET;
      s.codeAddr  <= PROG_RESET;
      s.stackPtr  <= STACK_RESET;
      s.lowLatch  <= PORT_RESET;
      s.gpLatch   <= PORT_RESET;
      s.highLatch <= PORT_RESET;
    end
    else
      s <= n;
  end

  cex_xdata_port u_xport (
    .core_clk      (core_clk),
    .reset         (reset),
    .bus           (xbus.port),
    .lowPortIn     (lowPortIn),
    .lowPortOut    (lowPortOut),
    .lowPortOe_n   (lowPortOe_n),
    .highPortOut   (highPortOut),
    .addrLatchEn   (addrLatchEn),
    .readStrobe_n  (readStrobe_n),
    .writeStrobe_n (writeStrobe_n)
  );

  assign codeAddr   = s.codeAddr;
  assign gpPortOut  = s.gpLatch;
  assign accOut     = s.acc;
  assign bRegOut    = s.bReg;
  assign statusOut  = s.status;
  assign stackOut   = s.stackPtr;
  assign dataPtrOut = {s.ptrHi, s.ptrLo};

endmodule // cex_exec_top

// ### verif/cex_exec_assertions.sv
`timescale 1ns/100ps
module cex_exec_checker
  import cex_pkg::*;
(
  input logic        core_clk,
  input logic        reset,
  input logic [15:0] codeAddr,
  input logic [7:0]  codeData,
  input logic [7:0]  lowPortOut,
  input logic        lowPortOe_n,
  input logic [7:0]  highPortOut,
  input logic        addrLatchEn,
  input logic        readStrobe_n,
  input logic        writeStrobe_n,
  input logic [7:0]  accOut,
  input logic [7:0]  bRegOut,
  input logic [7:0]  statusOut,
  input logic [7:0]  stackOut,
  input logic [15:0] dataPtrOut,
  input logic        instrBoundary
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire dec = instrBoundary;
  wire ptrOp = addrLatchEn && (codeData == OP_XRD_DP || codeData == OP_XWR_DP);

  a_latch_first: assert property (!(readStrobe_n && writeStrobe_n)
    |-> $past(addrLatchEn)) else $error("strobe without address phase");
  a_read_bus_free: assert property (!readStrobe_n
    |-> lowPortOe_n && !addrLatchEn) else $error("low port driven during read");
  a_ptr_address: assert property (ptrOp |-> lowPortOut == dataPtrOut[7:0]
    && highPortOut == dataPtrOut[15:8] ##1 highPortOut == dataPtrOut[15:8])
    else $error("pointer address wrong");
  a_high_latch_kept: assert property (ptrOp && $past(dec) |-> ##2
    addrLatchEn || highPortOut == $past(highPortOut, 3)) else $error("high latch lost");
  a_mul_flags: assert property (dec && codeData == OP_UMUL |=> (!dec) [*3] ##1
    dec && !statusOut[ST_CY] && statusOut[ST_OVF] == (bRegOut != 8'h00))
    else $error("multiply flags or length wrong");
  a_mul_product: assert property (dec && codeData == OP_UMUL |-> ##4
    {bRegOut, accOut} == {8'h00, $past(accOut, 4)} * {8'h00, $past(bRegOut, 4)})
    else $error("multiply product wrong");
  a_idle_advance: assert property (dec && codeData == OP_IDLE |=> dec
    && codeAddr == $past(codeAddr) + 16'h0001 && $stable(accOut) && $stable(statusOut)
    && $stable(stackOut) && $stable(dataPtrOut)) else $error("idle changed state");
  a_push_stack: assert property (dec && codeData == OP_PUSH |-> ##2 dec
    && stackOut == $past(stackOut, 2) + 8'h01) else $error("push stack wrong");
  a_pop_stack: assert property (dec && codeData == OP_POP ##1
    codeData != SFR_STACK |=> dec && stackOut == $past(stackOut, 2) - 8'h01)
    else $error("pop stack wrong");
  a_table_pointer: assert property (dec && codeData == OP_CTAB_DP |=>
    codeAddr == dataPtrOut + {8'h00, accOut} ##1 dec && accOut == $past(codeData)
    && $stable(dataPtrOut)) else $error("pointer table read wrong");
endmodule // cex_exec_checker

bind cex_exec_top cex_exec_checker cex_exec_checker_inst (.core_clk(core_clk), .reset(reset),
  .codeAddr(codeAddr), .codeData(codeData), .lowPortOut(lowPortOut),
  .lowPortOe_n(lowPortOe_n), .highPortOut(highPortOut), .addrLatchEn(addrLatchEn),
  .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .accOut(accOut),
  .bRegOut(bRegOut), .statusOut(statusOut), .stackOut(stackOut),
  .dataPtrOut(dataPtrOut), .instrBoundary(instrBoundary));

// ### verif/cex_xmem_model.sv
`timescale 1ns/100ps
module cex_xmem_model
(
  input  logic       core_clk,
  input  logic [7:0] portWire,
  input  logic [7:0] highPortOut,
  input  logic       addrLatchEn,
  input  logic       readStrobe_n,
  input  logic       writeStrobe_n,
  output logic [7:0] busDrive
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr = 16'h0000;

  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end

  always @(posedge core_clk)
  begin
    if (addrLatchEn)
      addr <= {highPortOut, portWire};
    if (!writeStrobe_n)
      mem[addr] <= portWire;
  end

  // Outside the read strobe the lines carry the inverse so a late sample is caught.
  assign busDrive = readStrobe_n ? ~mem[addr] : mem[addr];
endmodule // cex_xmem_model

// ### verif/cex_exec_top_bench.sv
`timescale 1ns/100ps
`define CHECK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errorCnt++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module cex_exec_top_bench;
  import cex_pkg::*;
  localparam logic [15:0] PROD = 16'h00D7 * 16'h00A0;
  localparam logic [7:0]  OVF  = 8'h01 << ST_OVF;
  localparam logic [7:0]  CYF  = 8'h01 << ST_CY;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] codeAddr;
  logic [7:0]  codeData;
  logic [7:0]  lowPortIn;
  logic [7:0]  lowPortOut;
  logic [7:0]  busDrive;
  logic        lowPortOe_n;
  logic [7:0]  highPortOut;
  logic        addrLatchEn;
  logic        readStrobe_n;
  logic        writeStrobe_n;
  logic [7:0]  gpPortPins = 8'h30;
  logic [7:0]  gpPortOut;
  logic [7:0]  accOut;
  logic [7:0]  bRegOut;
  logic [7:0]  statusOut;
  logic [7:0]  stackOut;
  logic [15:0] dataPtrOut;
  logic        instrBoundary;
  logic        unsupportedOp;
  int          errorCnt = 0;
  int          cmpCount = 0;
  int          cyc = 0;
  int          lastCyc = 0;
  int          nInstr = 0;
  int          unsupCnt = 0;
  logic [7:0]  prog [0:45] = '{8'h44, 8'hC3, 8'h43, 8'h00, 8'h55, 8'h48, 8'h43, 8'hF0,
    8'hA0, 8'hA4, 8'h00, 8'h72, 8'hE0, 8'hA0, 8'hE5, 8'hA0, 8'hE0, 8'h72, 8'hE0, 8'hC0,
    8'hF0, 8'hD0, 8'h82, 8'h43, 8'h83, 8'h12, 8'h44, 8'h80, 8'h93, 8'h83, 8'h00, 8'hF0,
    8'hE2, 8'hF3, 8'hE0, 8'h42, 8'h90, 8'h45, 8'h90, 8'hA5, 8'h47, 8'h00, 8'hD0, 8'hF0,
    8'hA4, 8'h00};
  int          len [0:28] = '{2, 3, 1, 3, 4, 1, 2, 2, 2, 2, 2, 2, 3, 2, 2, 2, 1, 2, 2, 2,
    2, 2, 2, 1, 1, 1, 2, 4, 1};

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction

  always #12.5 core_clk = ~core_clk;
  assign codeData = codeAddr < 16'h002E ? prog[codeAddr] :
    (codeAddr < 16'h0080 ? 8'h00 : pat(codeAddr));
  assign lowPortIn = !lowPortOe_n ? lowPortOut : busDrive;

  cex_exec_top cex_exec_top_inst (.core_clk(core_clk), .reset(reset), .codeAddr(codeAddr),
    .codeData(codeData), .lowPortIn(lowPortIn), .lowPortOut(lowPortOut),
    .lowPortOe_n(lowPortOe_n), .highPortOut(highPortOut), .addrLatchEn(addrLatchEn),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .gpPortPins(gpPortPins),
    .gpPortOut(gpPortOut), .accOut(accOut), .bRegOut(bRegOut), .statusOut(statusOut),
    .stackOut(stackOut), .dataPtrOut(dataPtrOut), .instrBoundary(instrBoundary),
    .unsupportedOp(unsupportedOp));
  cex_xmem_model cex_xmem_model_inst (.core_clk(core_clk), .portWire(lowPortIn),
    .highPortOut(highPortOut), .addrLatchEn(addrLatchEn), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n), .busDrive(busDrive));

  // Checks the state left behind once instruction k has completed.
  task automatic checkAfter(input int k);
    if (k == -1) `CHECK("stack", STACK_RESET, stackOut)
    if (k == -1) `CHECK("hiport", PORT_RESET, highPortOut)
    if (k == -1) `CHECK("ptr", 16'h0000, dataPtrOut)
    if (k == 0) `CHECK("acc", 8'hC3, accOut)
    if (k == 2) `CHECK("acc", 8'hC3 | 8'h55, accOut)
    if (k == 4) `CHECK("acc", PROD[7:0], accOut)
    if (k == 4) `CHECK("b", PROD[15:8], bRegOut)
    if (k == 4) `CHECK("status", OVF, statusOut)
    if (k == 5) `CHECK("acc", PROD[7:0], accOut)
    if (k == 5) `CHECK("stack", STACK_RESET, stackOut)
    if (k == 7) `CHECK("status", OVF, statusOut)
    if (k == 8) `CHECK("status", OVF | CYF, statusOut)
    if (k == 8) `CHECK("acc", PROD[7:0], accOut)
    if (k == 9) `CHECK("status", OVF | CYF, statusOut)
    if (k == 10) `CHECK("stack", STACK_RESET + 8'h01, stackOut)
    if (k == 11) `CHECK("stack", STACK_RESET, stackOut)
    if (k == 11) `CHECK("ptr", ({8'h00, PROD[15:8]}), dataPtrOut)
    if (k == 14) `CHECK("acc", pat(16'h1286 + 16'h00E0), accOut)
    if (k == 14) `CHECK("ptr", 16'h1286, dataPtrOut)
    if (k == 15) `CHECK("acc", pat(16'h001E + 16'h0075), accOut)
    if (k == 17) `CHECK("xmem", 8'h93, cex_xmem_model_inst.mem[16'h1286])
    if (k == 17) `CHECK("hiport", PORT_RESET, highPortOut)
    if (k == 18) `CHECK("acc", 8'h55 ^ 8'h5A, accOut)
    if (k == 19) `CHECK("xmem", 8'h55 ^ 8'h5A, cex_xmem_model_inst.mem[16'hFF00])
    if (k == 20) `CHECK("acc", 8'h93, accOut)
    if (k == 21) `CHECK("gpport", PORT_RESET, gpPortOut)
    if (k == 23) `CHECK("acc", 8'h93 | 8'h30, accOut)
    if (k == 24) `CHECK("acc", 8'h93 | 8'h30 | 8'h55, accOut)
    if (k == 24) `CHECK("status", OVF | CYF, statusOut)
    if (k == 25) `CHECK("unsup", 1, unsupCnt)
    if (k == 26) `CHECK("stack", STACK_RESET - 8'h01, stackOut)
    if (k == 26) `CHECK("b", 8'h00, bRegOut)
    if (k == 27) `CHECK("acc", 8'h00, accOut)
    if (k == 27) `CHECK("b", 8'h00, bRegOut)
    if (k == 27) `CHECK("status", 8'h00, statusOut)
  endtask

  // Samples once per cycle at the falling edge; runs in the stimulus process so reset release is not raced.
  task automatic observe();
    cyc++;
    if (unsupportedOp === 1'b1)
      unsupCnt++;
    if (instrBoundary === 1'b1)
    begin
      if (nInstr > 0 && nInstr <= 29)
        `CHECK("cycles", len[nInstr - 1], cyc - lastCyc)
      checkAfter(nInstr - 1);
      lastCyc = cyc;
      nInstr++;
    end
  endtask

  task automatic completeRun();
    if (errorCnt == 0 && cmpCount > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 200 && nInstr < 30; i++)
    begin
      observe();
      @(negedge core_clk);
    end
    `CHECK("progress", 1'b1, nInstr >= 30)
    completeRun();
  end

  initial
  begin
    repeat (2000) @(posedge core_clk);
    errorCnt++;
    completeRun();
  end
endmodule // cex_exec_top_bench
